// >>> hdl/out_map_pkg.sv
// Package with register map, field layout and widths of the output pin function selector.
package out_map_pkg;

  // Bus and register geometry.
  localparam int          APB_ADDR_W      = 12;
  localparam int          APB_DATA_W      = 32;
  localparam int          REG_W           = 16;
  localparam int          CODE_W          = 6;
  localparam int          NUM_REGS        = 4;
  localparam int          NUM_PINS        = 8;
  localparam int          NUM_FUNCS       = 64;

  // Byte offsets of the selector registers.
  localparam logic [11:0] OFS_PINS_48_49  = 12'h000;
  localparam logic [11:0] OFS_PINS_50_51  = 12'h004;
  localparam logic [11:0] OFS_PINS_52_53  = 12'h008;
  localparam logic [11:0] OFS_PINS_54_55  = 12'h00C;

  // Field positions inside each selector register.
  localparam int          LO_FIELD_LSB    = 0;
  localparam int          HI_FIELD_LSB    = 8;

  // Reset values.
  localparam logic [5:0]  CODE_RESET      = 6'h00;
  localparam logic [5:0]  CODE_NONE       = 6'h00;
  localparam logic [31:0] RDATA_ZERO      = 32'h0000_0000;

  // Bus decode result.
  typedef enum logic [2:0] {
    SEL_PINS_48_49,
    SEL_PINS_50_51,
    SEL_PINS_52_53,
    SEL_PINS_54_55,
    SEL_NONE
  } reg_sel_t;

endpackage

// >>> hdl/pin_func_mux.sv
// One remappable output pin: picks a peripheral output by its function code.
module pin_func_mux
  import out_map_pkg::*;
(
  // Selection.
  input  wire logic [CODE_W-1:0]    code_in,
  input  wire logic [NUM_FUNCS-1:0] periph_out_in,
  input  wire logic                 port_data_in,
  // Pin drive.
  output logic                      pin_out,
  output logic                      remapped_out
);

  // Code zero leaves the pin with ordinary port control.
  always_comb begin
    remapped_out = (code_in != CODE_NONE);
    pin_out      = remapped_out ? periph_out_in[code_in] : port_data_in;
  end

endmodule // pin_func_mux

// >>> hdl/output_pin_function_select.sv
// Top of the output pin function selector: APB registers and pin multiplexers for pins 48 to 55.
//
// Summary of operation
// - First register: bits 13-8 pick pin 49 function, bits 5-0 pin 48.
// - Second register: upper field picks pin 51 function, lower field pin 50.
// - Third register: upper field picks pin 53 function, lower field pin 52.
// - Fourth register: upper field picks pin 55 function, lower field pin 54.
// - Bits 15-14 of every register read zero and ignore writes.
// - Bits 7-6 of every register read zero and ignore writes.
// - Every selector field clears to zero at reset.
// - Fields are read/write; a read returns the last value written.
//
// Design decisions made here: the register addresses and the APB register port.
module output_pin_function_select
  import out_map_pkg::*;
(
  // Clock and reset.
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_in,
  // APB slave.
  input  wire logic                  psel_in,
  input  wire logic                  penable_in,
  input  wire logic                  pwrite_in,
  input  wire logic [APB_ADDR_W-1:0] paddr_in,
  input  wire logic [APB_DATA_W-1:0] pwdata_in,
  input  wire logic [3:0]            pstrb_in,
  output logic      [APB_DATA_W-1:0] prdata_out,
  output logic                       pready_out,
  output logic                       pslverr_out,
  // Peripheral outputs and ordinary port data.
  input  wire logic [NUM_FUNCS-1:0]  periph_out_in,
  input  wire logic [NUM_PINS-1:0]   port_data_in,
  // Remappable pins 48..55, bit 0 is pin 48.
  output logic      [NUM_PINS-1:0]   remap_pin_out,
  output logic      [NUM_PINS-1:0]   remap_active_out
);

  // Selector codes, one per pin.
  logic [CODE_W-1:0] pin48_function_code_r;
  logic [CODE_W-1:0] pin49_function_code_r;
  logic [CODE_W-1:0] pin50_function_code_r;
  logic [CODE_W-1:0] pin51_function_code_r;
  logic [CODE_W-1:0] pin52_function_code_r;
  logic [CODE_W-1:0] pin53_function_code_r;
  logic [CODE_W-1:0] pin54_function_code_r;
  logic [CODE_W-1:0] pin55_function_code_r;
  logic [CODE_W-1:0] code_vec [NUM_PINS];
  reg_sel_t          sel;
  logic              wr_lo;
  logic              wr_hi;
  logic              access;
  logic [REG_W-1:0]  rd_word;

  // Next values of the selector codes, one per pin.
  logic [CODE_W-1:0] pin48_function_code_nxt;
  logic [CODE_W-1:0] pin49_function_code_nxt;
  logic [CODE_W-1:0] pin50_function_code_nxt;
  logic [CODE_W-1:0] pin51_function_code_nxt;
  logic [CODE_W-1:0] pin52_function_code_nxt;
  logic [CODE_W-1:0] pin53_function_code_nxt;
  logic [CODE_W-1:0] pin54_function_code_nxt;
  logic [CODE_W-1:0] pin55_function_code_nxt;
  // Write enable of each pin's field, bit 0 is pin 48.
  logic [NUM_PINS-1:0]   field_we;
  // Registered read data, its next value and the setup phase flag.
  logic [APB_DATA_W-1:0] prdata_r;
  logic [APB_DATA_W-1:0] prdata_nxt;
  logic                  setup;

  // How the block behaves, for whoever integrates it.
  // Each pin has its own six-bit code register. A code of zero hands the pin back
  // to the ordinary port latch, and any other code picks one peripheral output.
  // The code-to-function table lives outside this block; the multiplexers only
  // index the peripheral bundle, so bundle bit 0 is never routed to a pin.
  // A write lands on the rising edge that ends the access cycle, and the pin
  // follows the new code from the next cycle on.
  // The pin path stays combinational from the code flip-flops to the pin, since
  // a pipeline stage there would add a cycle of lag to every peripheral signal.
  // Byte strobes let software rewrite one pin of a pair without touching the
  // other, which avoids a read-modify-write race between bus masters.
  // Unmapped addresses answer with an error response and change nothing.
  // Read data is registered and is valid only in the access cycle of a read.

  // Address decode shared by read and write paths.
  function automatic reg_sel_t decode(input logic [APB_ADDR_W-1:0] addr);
    case (addr)
      OFS_PINS_48_49: decode = SEL_PINS_48_49;
      OFS_PINS_50_51: decode = SEL_PINS_50_51;
      OFS_PINS_52_53: decode = SEL_PINS_52_53;
      OFS_PINS_54_55: decode = SEL_PINS_54_55;
      default:        decode = SEL_NONE;
    endcase
  endfunction

  // Packs two codes into a register image; unused bits are forced to zero.
  function automatic logic [REG_W-1:0] pack(input logic [CODE_W-1:0] hi,
                                            input logic [CODE_W-1:0] lo);
    pack                                     = '0;
    pack[HI_FIELD_LSB +: CODE_W]             = hi;
    pack[LO_FIELD_LSB +: CODE_W]             = lo;
  endfunction

  // Extracts the low selector field; bits 7-6 of the bus word fall away here.
  function automatic logic [CODE_W-1:0] lo_field(input logic [APB_DATA_W-1:0] word);
    lo_field = word[LO_FIELD_LSB +: CODE_W];
  endfunction

  // Extracts the high selector field; bits 15-14 and the upper half fall away here.
  function automatic logic [CODE_W-1:0] hi_field(input logic [APB_DATA_W-1:0] word);
    hi_field = word[HI_FIELD_LSB +: CODE_W];
  endfunction

  // Zero wait states: every access completes in its first access cycle.
  assign access      = psel_in && penable_in;
  assign pready_out  = 1'b1;
  assign sel         = decode(paddr_in);
  // Unmapped addresses answer with an error so software sees the mistake.
  assign pslverr_out = access && (sel == SEL_NONE);
  // Byte lane 0 carries the low field, lane 1 the high field.
  assign wr_lo       = access && pwrite_in && pstrb_in[0];
  assign wr_hi       = access && pwrite_in && pstrb_in[1];
  // Setup phase of a transfer, where the read word is captured.
  assign setup       = psel_in && !penable_in;

  // One enable per pin: the register hit and the byte lane that carries its field.
  assign field_we[0] = wr_lo && (sel == SEL_PINS_48_49);
  assign field_we[1] = wr_hi && (sel == SEL_PINS_48_49);
  assign field_we[2] = wr_lo && (sel == SEL_PINS_50_51);
  assign field_we[3] = wr_hi && (sel == SEL_PINS_50_51);
  assign field_we[4] = wr_lo && (sel == SEL_PINS_52_53);
  assign field_we[5] = wr_hi && (sel == SEL_PINS_52_53);
  assign field_we[6] = wr_lo && (sel == SEL_PINS_54_55);
  assign field_we[7] = wr_hi && (sel == SEL_PINS_54_55);

  // Pin 48 next code: the low field of the first register when written,
  // otherwise the code it already holds.
  always_comb begin
    pin48_function_code_nxt = pin48_function_code_r;
    if (field_we[0]) begin
      pin48_function_code_nxt = lo_field(pwdata_in);
    end
  end

  // Pin 48 code register; reset clears it, so the pin comes up under
  // ordinary port control until software picks a function.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pin48_function_code_r <= CODE_RESET;
    end else begin
      pin48_function_code_r <= pin48_function_code_nxt;
    end
  end

  // Pin 49 next code: the high field of the first register when written,
  // otherwise the code it already holds.
  always_comb begin
    pin49_function_code_nxt = pin49_function_code_r;
    if (field_we[1]) begin
      pin49_function_code_nxt = hi_field(pwdata_in);
    end
  end

  // Pin 49 code register; reset clears it, so the pin comes up under
  // ordinary port control until software picks a function.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pin49_function_code_r <= CODE_RESET;
    end else begin
      pin49_function_code_r <= pin49_function_code_nxt;
    end
  end

  // Pin 50 next code: the low field of the second register when written,
  // otherwise the code it already holds.
  always_comb begin
    pin50_function_code_nxt = pin50_function_code_r;
    if (field_we[2]) begin
      pin50_function_code_nxt = lo_field(pwdata_in);
    end
  end

  // Pin 50 code register; reset clears it, so the pin comes up under
  // ordinary port control until software picks a function.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pin50_function_code_r <= CODE_RESET;
    end else begin
      pin50_function_code_r <= pin50_function_code_nxt;
    end
  end

  // Pin 51 next code: the high field of the second register when written,
  // otherwise the code it already holds.
  always_comb begin
    pin51_function_code_nxt = pin51_function_code_r;
    if (field_we[3]) begin
      pin51_function_code_nxt = hi_field(pwdata_in);
    end
  end

  // Pin 51 code register; reset clears it, so the pin comes up under
  // ordinary port control until software picks a function.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pin51_function_code_r <= CODE_RESET;
    end else begin
      pin51_function_code_r <= pin51_function_code_nxt;
    end
  end

  // Pin 52 next code: the low field of the third register when written,
  // otherwise the code it already holds.
  always_comb begin
    pin52_function_code_nxt = pin52_function_code_r;
    if (field_we[4]) begin
      pin52_function_code_nxt = lo_field(pwdata_in);
    end
  end

  // Pin 52 code register; reset clears it, so the pin comes up under
  // ordinary port control until software picks a function.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pin52_function_code_r <= CODE_RESET;
    end else begin
      pin52_function_code_r <= pin52_function_code_nxt;
    end
  end

  // Pin 53 next code: the high field of the third register when written,
  // otherwise the code it already holds.
  always_comb begin
    pin53_function_code_nxt = pin53_function_code_r;
    if (field_we[5]) begin
      pin53_function_code_nxt = hi_field(pwdata_in);
    end
  end

  // Pin 53 code register; reset clears it, so the pin comes up under
  // ordinary port control until software picks a function.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pin53_function_code_r <= CODE_RESET;
    end else begin
      pin53_function_code_r <= pin53_function_code_nxt;
    end
  end

  // Pin 54 next code: the low field of the fourth register when written,
  // otherwise the code it already holds.
  always_comb begin
    pin54_function_code_nxt = pin54_function_code_r;
    if (field_we[6]) begin
      pin54_function_code_nxt = lo_field(pwdata_in);
    end
  end

  // Pin 54 code register; reset clears it, so the pin comes up under
  // ordinary port control until software picks a function.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pin54_function_code_r <= CODE_RESET;
    end else begin
      pin54_function_code_r <= pin54_function_code_nxt;
    end
  end

  // Pin 55 next code: the high field of the fourth register when written,
  // otherwise the code it already holds.
  always_comb begin
    pin55_function_code_nxt = pin55_function_code_r;
    if (field_we[7]) begin
      pin55_function_code_nxt = hi_field(pwdata_in);
    end
  end

  // Pin 55 code register; reset clears it, so the pin comes up under
  // ordinary port control until software picks a function.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pin55_function_code_r <= CODE_RESET;
    end else begin
      pin55_function_code_r <= pin55_function_code_nxt;
    end
  end

  // Read mux; unused bits come back as zero from the pack function.
  always_comb begin
    case (sel)
      SEL_PINS_48_49: rd_word = pack(pin49_function_code_r, pin48_function_code_r);
      SEL_PINS_50_51: rd_word = pack(pin51_function_code_r, pin50_function_code_r);
      SEL_PINS_52_53: rd_word = pack(pin53_function_code_r, pin52_function_code_r);
      SEL_PINS_54_55: rd_word = pack(pin55_function_code_r, pin54_function_code_r);
      default:        rd_word = '0;
    endcase
  end

  // Load on a read setup and clear otherwise, so the bus sees zero outside a read access.
  always_comb begin
    prdata_nxt = RDATA_ZERO;
    if (setup && !pwrite_in) begin
      prdata_nxt = APB_DATA_W'(rd_word);
    end
  end

  // Read data register; no write can fall between the setup and access cycles of one
  // transfer, so the captured word still matches the register contents.
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      prdata_r <= RDATA_ZERO;
    end else begin
      prdata_r <= prdata_nxt;
    end
  end

  // Read data comes straight from the flip-flop, with no wait state added.
  assign prdata_out = prdata_r;

  // Codes gathered in pin order for the multiplexers.
  assign code_vec[0] = pin48_function_code_r;
  assign code_vec[1] = pin49_function_code_r;
  assign code_vec[2] = pin50_function_code_r;
  assign code_vec[3] = pin51_function_code_r;
  assign code_vec[4] = pin52_function_code_r;
  assign code_vec[5] = pin53_function_code_r;
  assign code_vec[6] = pin54_function_code_r;
  assign code_vec[7] = pin55_function_code_r;

  // Pin multiplexers act straight from the registers, so a new code shows one cycle on.
  for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
    pin_func_mux u_mux (
      .code_in       (code_vec[i]),
      .periph_out_in (periph_out_in),
      .port_data_in  (port_data_in[i]),
      .pin_out       (remap_pin_out[i]),
      .remapped_out  (remap_active_out[i])
    );
  end

endmodule // output_pin_function_select

// >>> verification/output_pin_function_select_props.sv
// Checker for the output pin function selector, bound to its ports.
module output_pin_function_select_props
  import out_map_pkg::*;
(
  // Clock, reset and APB.
  input wire logic                  core_clk_in,
  input wire logic                  rst_in,
  input wire logic                  psel_in,
  input wire logic                  penable_in,
  input wire logic                  pwrite_in,
  input wire logic [APB_ADDR_W-1:0] paddr_in,
  input wire logic [APB_DATA_W-1:0] pwdata_in,
  input wire logic [3:0]            pstrb_in,
  input wire logic [APB_DATA_W-1:0] prdata_out,
  input wire logic                  pready_out,
  input wire logic                  pslverr_out,
  // Pin side.
  input wire logic [NUM_FUNCS-1:0]  periph_out_in,
  input wire logic [NUM_PINS-1:0]   port_data_in,
  input wire logic [NUM_PINS-1:0]   remap_pin_out,
  input wire logic [NUM_PINS-1:0]   remap_active_out
);
  // Only aligned words below 0x010 are mapped, so stray writes never count.
  wire logic wr = psel_in & penable_in & pwrite_in & ~|paddr_in[11:4] & ~|paddr_in[1:0];
  wire logic rd = psel_in & penable_in & ~pwrite_in;
  wire logic wl = wr & pstrb_in[0];
  wire logic wh = wr & pstrb_in[1];
  wire logic [7:0] idle_bad = ~remap_active_out & (remap_pin_out ^ port_data_in);
  logic [2:0] pin_r;
  logic [5:0] lo_r, hi_r;
  // Remember the low pin index and both codes of the access just taken.
  always_ff @(posedge core_clk_in) begin
    pin_r <= {paddr_in[3:2], 1'b0};
    lo_r  <= pwdata_in[5:0];
    hi_r  <= pwdata_in[13:8];
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  AST_RST_CLEAR: assert property ($fell(rst_in) |-> remap_active_out == 8'h00)
    else $error("Codes not clear after reset.");
  AST_PORT_CTRL: assert property (idle_bad == 8'h00)
    else $error("Idle pin not under port control.");
  AST_RD_ZERO: assert property (rd |-> ~|(prdata_out & 32'hFFFF_C0C0))
    else $error("Unused bits read nonzero.");
  AST_LO_ACT: assert property (wl |=> remap_active_out[pin_r] == |lo_r)
    else $error("Low pin activity wrong.");
  AST_HI_ACT: assert property (wh |=> remap_active_out[pin_r | 3'd1] == |hi_r)
    else $error("High pin activity wrong.");
  AST_LO_ROUTE: assert property (
    wl && |pwdata_in[5:0] |=> remap_pin_out[pin_r] == periph_out_in[lo_r])
    else $error("Low pin routed wrongly.");
  AST_HI_ROUTE: assert property (
    wh && |pwdata_in[13:8] |=> remap_pin_out[pin_r | 3'd1] == periph_out_in[hi_r])
    else $error("High pin routed wrongly.");
  AST_HOLD: assert property (!wr |=> $stable(remap_active_out))
    else $error("Codes changed without a write.");
  // Main traffic seen at least once.
  C_WR: cover property (wl && |pwdata_in[5:0]);
  C_RD: cover property (rd);
  C_ERR: cover property (psel_in && penable_in && pslverr_out);
endmodule // output_pin_function_select_props

bind output_pin_function_select output_pin_function_select_props chk_i (.core_clk_in, .rst_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in, .prdata_out, .pready_out,
  .pslverr_out, .periph_out_in, .port_data_in, .remap_pin_out, .remap_active_out);

// >>> verification/test_output_pin_function_select.sv
// Self-checking bench for the output pin function selector.
module test_output_pin_function_select
  import out_map_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, prdy, perr, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic [3:0]  pstrb = 4'h0;
  logic [63:0] periph = 64'hA5A5_5A5A_C3C3_3C3C;
  logic [7:0]  port = 8'h00, pins, act;
  int          failures = 0, checked = 0, cyc = 0;
  // The clock runs at 50 MHz.
  always #10 clk = ~clk;
  output_pin_function_select output_pin_function_select_i (.core_clk_in(clk), .rst_in(rst),
    .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .pstrb_in(pstrb), .prdata_out(prdata), .pready_out(prdy), .pslverr_out(perr),
    .periph_out_in(periph), .port_data_in(port), .remap_pin_out(pins), .remap_active_out(act));
  // Prints the verdict once and stops.
  task automatic end_sim;
    if (failures == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Counts every comparison and reports a mismatch at once.
  task automatic cmp(input logic [31:0] g, logic [31:0] x);
    checked++;
    if (g !== x) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // One APB transfer; the request holds until pready is seen at a rising edge.
  task automatic xfer(input logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (prdy !== 1'b1);
    q = prdata;
    e = perr;
    {psel, pen} <= 2'b00;
  endtask
  task automatic rd(input logic [11:0] a, logic [31:0] x);
    xfer(1'b0, a, 32'h0000_0000, 4'h0);
    cmp(q, x);
  endtask
  // Pin p carries function p+1 where mask bit p is set, else its port data.
  task automatic chk_pins(input logic [7:0] m);
    @(negedge clk);
    for (int p = 0; p < 8; p++) begin
      cmp(32'(pins[p]), 32'(m[p] ? periph[p+1] : port[p]));
    end
    cmp(32'(act), 32'(m));
  endtask
  // A hang is cut short well past the fewer than a hundred cycles the tests need.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      failures++;
      end_sim();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rd(12'(4 * i), 32'h0000_0000);
    chk_pins(8'h00);
    // Pin p gets code p+1, with every unused bit written as one.
    for (int i = 0; i < 4; i++) begin
      xfer(1'b1, 12'(4 * i), 32'hFFFF_C0C0 | 32'((2*i+2) << 8 | (2*i+1)), 4'hF);
    end
    for (int i = 0; i < 4; i++) begin
      rd(12'(4 * i), 32'((2*i+2) << 8 | (2*i+1)));
    end
    chk_pins(8'hFF);
    // Flipping the sources shows the pins follow live peripheral data.
    @(posedge clk);
    periph <= ~periph;
    chk_pins(8'hFF);
    xfer(1'b1, 12'h000, 32'h0000_3F3F, 4'h1);
    rd(12'h000, 32'h0000_023F);
    port <= 8'h3C;
    xfer(1'b1, 12'h000, 32'h0000_0000, 4'hF);
    chk_pins(8'hFC);
    // A write with only the upper lane strobed leaves the low field alone.
    xfer(1'b1, 12'h004, 32'h0000_2A15, 4'h2);
    rd(12'h004, 32'h0000_2A03);
    xfer(1'b1, 12'h010, 32'h0000_0101, 4'hF);
    cmp(32'(e), 32'h0000_0001);
    rd(12'h000, 32'h0000_0000);
    // A second reset in mid-run must clear every field again.
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rd(12'(4 * i), 32'h0000_0000);
    chk_pins(8'h00);
    end_sim();
  end
endmodule // test_output_pin_function_select
